/* File: rtl/sdseq_ctrl.sv */
// controller end: power-up init, self-refresh entry/exit and clock suspension
`timescale 1ns/1ns
`include "sdseq_cfg.svh"

module sdseq_ctrl #(
  parameter int INIT_CYC   = `SDSEQ_INIT_CYC,
  parameter bit FAST_GRADE = 1'b0,
  parameter int SRX_CYC    = `SDSEQ_SRX_CYC,
  parameter int STABLE_CYC = `SDSEQ_CLK_STABLE_CYC,
  parameter int INIT_REF   = `SDSEQ_INIT_REFRESH,
  parameter int BURST_REF  = `SDSEQ_BURST_REFRESH
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  sdseq_if.ctrl                         bus,
  input  wire logic [`SDSEQ_ADDR_W-1:0] mode_word,
  input  wire logic                     burst_refresh,
  input  wire logic                     sr_req,
  input  wire logic                     suspend_req,
  input  wire logic                     cmd_valid,
  input  wire sdseq_pkg::sdseq_op_type  cmd_op,
  input  wire logic [`SDSEQ_BANK_W-1:0] cmd_bank,
  input  wire logic [`SDSEQ_ADDR_W-1:0] cmd_addr,
  output logic                          cmd_ready,
  output logic                          init_done,
  output logic                          in_self_refresh
);

  // ----------------------------------------------------------------
  // cycle counts
  // ----------------------------------------------------------------
  localparam int RC_CYC  = FAST_GRADE ? `SDSEQ_CYC(`SDSEQ_T_RC_FAST_NS)
                                      : `SDSEQ_CYC(`SDSEQ_T_RC_SLOW_NS);
  localparam int RP_CYC  = FAST_GRADE ? `SDSEQ_CYC(`SDSEQ_T_RP_FAST_NS)
                                      : `SDSEQ_CYC(`SDSEQ_T_RP_SLOW_NS);
  localparam int RAS_CYC = FAST_GRADE ? `SDSEQ_CYC(`SDSEQ_T_RAS_FAST_NS)
                                      : `SDSEQ_CYC(`SDSEQ_T_RAS_SLOW_NS);
  localparam int EXIT_CYC = (RC_CYC > SRX_CYC) ? RC_CYC : SRX_CYC;

  // counter value that puts the next command n cycles after this one
  function automatic logic [15:0] gap(input int n);
    gap = (n >= 2) ? 16'(n - 2) : 16'h0000;
  endfunction

  function automatic sdseq_pkg::sdseq_cmd_type op_cmd(input sdseq_pkg::sdseq_op_type op);
    case (op)
      sdseq_pkg::OP_ACT: op_cmd = sdseq_pkg::CMD_ACT;
      sdseq_pkg::OP_RD:  op_cmd = sdseq_pkg::CMD_RD;
      sdseq_pkg::OP_WR:  op_cmd = sdseq_pkg::CMD_WR;
      sdseq_pkg::OP_PRE: op_cmd = sdseq_pkg::CMD_PRE;
      default:           op_cmd = sdseq_pkg::CMD_REF;
    endcase
  endfunction

  sdseq_pkg::sdseq_state_type state;
  sdseq_pkg::sdseq_phase_type phase;
  logic [15:0]                wait_cnt;
  logic [15:0]                rc_cnt;
  logic [11:0]                ref_cnt;
  logic [11:0]                ref_target;
  logic                       wait_done;
  logic                       rc_ok;
  logic                       take;
  logic                       ref_go;
  logic                       row_op;
  sdseq_pkg::sdseq_cmd_type   next_cmd;
  logic                       next_cke;
  logic                       next_clk_run;
  logic [`SDSEQ_BANK_W-1:0]   next_ba;
  logic [`SDSEQ_ADDR_W-1:0]   next_addr;

  assign wait_done  = (wait_cnt == 16'h0000);
  assign rc_ok      = (rc_cnt == 16'h0000);
  assign ref_target = (phase == sdseq_pkg::PH_INIT) ? 12'(INIT_REF) : 12'(BURST_REF);
  assign row_op     = (cmd_op == sdseq_pkg::OP_ACT) || (cmd_op == sdseq_pkg::OP_REF);
  assign ref_go     = (state == sdseq_pkg::ST_REF) && rc_ok;
  // row commands wait out the row cycle; column and precharge go straight
  assign cmd_ready  = (state == sdseq_pkg::ST_IDLE) && !sr_req && !suspend_req &&
                      (rc_ok || !row_op);
  assign take       = cmd_valid && cmd_ready;

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= sdseq_pkg::ST_PWR;
      phase    <= sdseq_pkg::PH_INIT;
      wait_cnt <= 16'(INIT_CYC - 1);
    end else begin
      if (!wait_done) begin
        wait_cnt <= wait_cnt - 16'h0001;
      end
      case (state)
        sdseq_pkg::ST_PWR: begin
          if (wait_done) begin
            state <= sdseq_pkg::ST_PRE;
          end
        end
        sdseq_pkg::ST_PRE: begin
          state    <= sdseq_pkg::ST_PRE_W;
          wait_cnt <= gap(RP_CYC);
        end
        sdseq_pkg::ST_PRE_W: begin
          if (wait_done) begin
            state <= sdseq_pkg::ST_MRS;
          end
        end
        sdseq_pkg::ST_MRS: begin
          state    <= sdseq_pkg::ST_MRS_W;
          wait_cnt <= gap(`SDSEQ_T_MRS_CYC);
        end
        sdseq_pkg::ST_MRS_W: begin
          if (wait_done) begin
            state <= sdseq_pkg::ST_REF;
          end
        end
        sdseq_pkg::ST_REF: begin
          if (rc_ok) begin
            state    <= sdseq_pkg::ST_REF_W;
            wait_cnt <= gap(RC_CYC);
          end
        end
        sdseq_pkg::ST_REF_W: begin
          if (wait_done) begin
            if (ref_cnt < ref_target) begin
              state <= sdseq_pkg::ST_REF;
            end else if (phase == sdseq_pkg::PH_PRE) begin
              state <= sdseq_pkg::ST_SR_IN;
            end else begin
              state <= sdseq_pkg::ST_IDLE;
            end
          end
        end
        sdseq_pkg::ST_IDLE: begin
          if (sr_req && burst_refresh) begin
            state <= sdseq_pkg::ST_REF;
            phase <= sdseq_pkg::PH_PRE;
          end else if (sr_req) begin
            state <= sdseq_pkg::ST_SR_IN;
          end else if (suspend_req) begin
            state <= sdseq_pkg::ST_SUSP;
          end
        end
        sdseq_pkg::ST_SR_IN: begin
          if (rc_ok) begin
            state    <= sdseq_pkg::ST_SR_HOLD;
            wait_cnt <= 16'(RAS_CYC - 1);
          end
        end
        sdseq_pkg::ST_SR_HOLD: begin
          if (wait_done && !sr_req) begin
            state    <= sdseq_pkg::ST_SR_CLK;
            wait_cnt <= 16'(STABLE_CYC - 1);
          end
        end
        sdseq_pkg::ST_SR_CLK: begin
          if (wait_done) begin
            state    <= sdseq_pkg::ST_SR_EXIT;
            wait_cnt <= 16'(EXIT_CYC - 1);
          end
        end
        sdseq_pkg::ST_SR_EXIT: begin
          if (wait_done) begin
            state <= burst_refresh ? sdseq_pkg::ST_REF : sdseq_pkg::ST_IDLE;
            phase <= sdseq_pkg::PH_POST;
          end
        end
        sdseq_pkg::ST_SUSP: begin
          if (!suspend_req) begin
            state <= sdseq_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= sdseq_pkg::ST_PWR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // refresh and row cycle counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_cnt <= '0;
    end else if (ref_go) begin
      ref_cnt <= ref_cnt + 12'h001;
    end else if (state != sdseq_pkg::ST_REF && state != sdseq_pkg::ST_REF_W) begin
      ref_cnt <= '0;
    end
  end

  // the device row timer is global here: safe for any bank, slower for interleaving
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rc_cnt <= '0;
    end else if (ref_go || (take && row_op)) begin
      rc_cnt <= 16'(RC_CYC - 1);
    end else if (!rc_ok) begin
      rc_cnt <= rc_cnt - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // pin values
  // ----------------------------------------------------------------
  always_comb begin
    next_cmd     = sdseq_pkg::CMD_NOP;
    next_cke     = 1'b1;
    next_clk_run = 1'b1;
    next_ba      = '0;
    next_addr    = '0;
    case (state)
      sdseq_pkg::ST_PRE: begin
        next_cmd                       = sdseq_pkg::CMD_PRE;
        next_addr[`SDSEQ_ALL_BANKS_BIT] = 1'b1;
      end
      sdseq_pkg::ST_MRS: begin
        next_cmd  = sdseq_pkg::CMD_MRS;
        next_addr = mode_word;
      end
      sdseq_pkg::ST_REF: begin
        if (rc_ok) begin
          next_cmd = sdseq_pkg::CMD_REF;
        end
      end
      sdseq_pkg::ST_IDLE: begin
        if (take) begin
          next_cmd  = op_cmd(cmd_op);
          next_ba   = cmd_bank;
          next_addr = cmd_addr;
        end
      end
      sdseq_pkg::ST_SR_IN: begin
        next_cke = !rc_ok;
        if (rc_ok) begin
          next_cmd = sdseq_pkg::CMD_REF;
        end
      end
      sdseq_pkg::ST_SR_HOLD: begin
        next_cke     = 1'b0;
        next_clk_run = 1'b0;
      end
      sdseq_pkg::ST_SR_CLK: begin
        next_cke = 1'b0;
      end
      sdseq_pkg::ST_SR_EXIT: begin
        next_cmd = sdseq_pkg::CMD_DESEL;
      end
      sdseq_pkg::ST_SUSP: begin
        next_cke = 1'b0;
      end
      default: begin
        next_cmd = sdseq_pkg::CMD_NOP;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus.clk_run <= 1'b1;
      bus.cke     <= 1'b1;
      {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= sdseq_pkg::CMD_NOP;
      bus.ba      <= '0;
      bus.addr    <= '0;
    end else begin
      bus.clk_run <= next_clk_run;
      bus.cke     <= next_cke;
      {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= next_cmd;
      bus.ba      <= next_ba;
      bus.addr    <= next_addr;
    end
  end

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_done       <= 1'b0;
      in_self_refresh <= 1'b0;
      bus.dqm         <= 1'b1;
    end else begin
      if (state == sdseq_pkg::ST_REF_W && wait_done && phase == sdseq_pkg::PH_INIT &&
          ref_cnt >= ref_target) begin
        init_done <= 1'b1;
        bus.dqm   <= 1'b0;
      end
      in_self_refresh <= (state == sdseq_pkg::ST_SR_HOLD) || (state == sdseq_pkg::ST_SR_CLK);
    end
  end

endmodule

/* File: rtl/sdseq_cfg.svh */
// timing counts, field positions and sequence constants for the sdram sequencer
`ifndef SDSEQ_CFG_SVH
`define SDSEQ_CFG_SVH

// ----------------------------------------------------------------
// clock and conversion
// ----------------------------------------------------------------
`define SDSEQ_CLK_PS          8000
// least times round up to whole cycles
`define SDSEQ_CYC(ns)         ((((ns) * 1000) + `SDSEQ_CLK_PS - 1) / `SDSEQ_CLK_PS)

// ----------------------------------------------------------------
// times, as printed
// ----------------------------------------------------------------
`define SDSEQ_T_INIT_US       200
`define SDSEQ_T_RC_FAST_NS    60
`define SDSEQ_T_RC_SLOW_NS    70
`define SDSEQ_T_RP_FAST_NS    18
`define SDSEQ_T_RP_SLOW_NS    20
`define SDSEQ_T_RAS_FAST_NS   42
`define SDSEQ_T_RAS_SLOW_NS   45
`define SDSEQ_T_MRS_CYC       2
`define SDSEQ_SRX_CYC         2
`define SDSEQ_CLK_STABLE_CYC  4

// ----------------------------------------------------------------
// counts and fields
// ----------------------------------------------------------------
`define SDSEQ_INIT_CYC        `SDSEQ_CYC(`SDSEQ_T_INIT_US * 1000)
`define SDSEQ_INIT_REFRESH    2
`define SDSEQ_BURST_REFRESH   2048
`define SDSEQ_BURST_LEN       4
`define SDSEQ_ADDR_W          12
`define SDSEQ_BANK_W          2
`define SDSEQ_ALL_BANKS_BIT   10

`endif

/* File: rtl/sdseq_pkg.sv */
// shared types of the sdram sequencer
package sdseq_pkg;

  // ----------------------------------------------------------------
  // pin command {chip_select_n, row_strobe_n, column_strobe_n, we_n}
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_MRS   = 4'h0,
    CMD_REF   = 4'h1,
    CMD_PRE   = 4'h2,
    CMD_ACT   = 4'h3,
    CMD_WR    = 4'h4,
    CMD_RD    = 4'h5,
    CMD_NOP   = 4'h7,
    CMD_DESEL = 4'hf
  } sdseq_cmd_type;

  // ----------------------------------------------------------------
  // user operations and controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_ACT = 3'h0,
    OP_RD  = 3'h1,
    OP_WR  = 3'h2,
    OP_PRE = 3'h3,
    OP_REF = 3'h4
  } sdseq_op_type;

  typedef enum logic [1:0] {
    PH_INIT = 2'h0,
    PH_PRE  = 2'h1,
    PH_POST = 2'h2
  } sdseq_phase_type;

  typedef enum logic [3:0] {
    ST_PWR     = 4'h0,
    ST_PRE     = 4'h1,
    ST_PRE_W   = 4'h3,
    ST_MRS     = 4'h2,
    ST_MRS_W   = 4'h6,
    ST_REF     = 4'h7,
    ST_REF_W   = 4'h5,
    ST_IDLE    = 4'h4,
    ST_SR_IN   = 4'hc,
    ST_SR_HOLD = 4'hd,
    ST_SR_CLK  = 4'hf,
    ST_SR_EXIT = 4'he,
    ST_SUSP    = 4'ha
  } sdseq_state_type;

endpackage

/* File: rtl/sdseq_if.sv */
// pin-level link between the controller end and the memory end
`timescale 1ns/1ns
`include "sdseq_cfg.svh"

interface sdseq_if;
  logic                      clk_run;
  logic                      cke;
  logic                      cs_n;
  logic                      ras_n;
  logic                      cas_n;
  logic                      we_n;
  logic                      dqm;
  logic [`SDSEQ_BANK_W-1:0]  ba;
  logic [`SDSEQ_ADDR_W-1:0]  addr;

  modport ctrl (output clk_run, cke, cs_n, ras_n, cas_n, we_n, dqm, ba, addr);
  modport mem  (input  clk_run, cke, cs_n, ras_n, cas_n, we_n, dqm, ba, addr);
endinterface

/* File: rtl/sdseq_mem.sv */
// memory end: self-refresh tracking, clock suspension and command capture
`timescale 1ns/1ns
`include "sdseq_cfg.svh"

module sdseq_mem #(
  parameter int BURST_LEN = `SDSEQ_BURST_LEN
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  sdseq_if.mem                          bus,
  output logic                          self_refresh,
  output logic                          int_clk_en,
  output logic                          cmd_strobe,
  output sdseq_pkg::sdseq_cmd_type      cmd_code,
  output logic [`SDSEQ_ADDR_W-1:0]      mode_reg,
  output logic                          burst_active
);

  sdseq_pkg::sdseq_cmd_type cmd;
  logic                     live;
  logic [7:0]               burst_left;

  assign cmd  = sdseq_pkg::sdseq_cmd_type'({bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n});
  // a command counts only while the clock ran in the previous cycle
  assign live = int_clk_en && !self_refresh;

  // ----------------------------------------------------------------
  // clock suspension lags clock_gate_input by one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_clk_en <= 1'b0;
    end else begin
      int_clk_en <= bus.cke;
    end
  end

  // ----------------------------------------------------------------
  // self-refresh: only clock_gate_input is watched once inside
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      self_refresh <= 1'b0;
    end else if (self_refresh) begin
      self_refresh <= !bus.cke;
    end else if (live && !bus.cke && cmd == sdseq_pkg::CMD_REF) begin
      self_refresh <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // command capture and burst freeze
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_strobe <= 1'b0;
      cmd_code   <= sdseq_pkg::CMD_NOP;
      mode_reg   <= '0;
    end else begin
      cmd_strobe <= live && bus.cke && !bus.cs_n && cmd != sdseq_pkg::CMD_NOP;
      if (live) begin
        cmd_code <= cmd;
      end
      if (live && cmd == sdseq_pkg::CMD_MRS) begin
        mode_reg <= bus.addr;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      burst_left <= '0;
    end else if (live && (cmd == sdseq_pkg::CMD_RD || cmd == sdseq_pkg::CMD_WR)) begin
      burst_left <= 8'(BURST_LEN);
    end else if (int_clk_en && burst_left != 8'h00) begin
      // a suspended clock holds the burst where it stands
      burst_left <= burst_left - 8'h01;
    end
  end

  assign burst_active = (burst_left != 8'h00);

endmodule

/* File: test/sdseq_asserts.sv */
// pin-level assertions between the controller end and the memory end
`timescale 1ns/1ns
`include "sdseq_cfg.svh"

module sdseq_asserts #(
  parameter int INIT_CYC = 20,
  parameter int RC_CYC   = 9
) (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     clk_run,
  input wire logic                     cke,
  input wire logic                     cs_n,
  input wire logic                     ras_n,
  input wire logic                     cas_n,
  input wire logic                     we_n,
  input wire logic                     dqm,
  input wire logic [`SDSEQ_BANK_W-1:0] ba,
  input wire logic [`SDSEQ_ADDR_W-1:0] addr
);
  // --------------------
  // helper state
  // --------------------
  logic [3:0] cmd;
  logic       act_ref;
  logic       seen;
  logic       in_sr;
  int         cyc;
  int         rc_cnt;
  int         n_ref;

  assign cmd     = {cs_n, ras_n, cas_n, we_n};
  assign act_ref = cke && (cmd == sdseq_pkg::CMD_ACT || cmd == sdseq_pkg::CMD_REF);

  // timer is global over banks, so it is stricter than same-bank spacing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc    <= 0;
      rc_cnt <= 0;
      n_ref  <= 0;
      seen   <= 1'b0;
      in_sr  <= 1'b0;
    end else begin
      cyc    <= (cyc < INIT_CYC) ? cyc + 1 : cyc;
      rc_cnt <= act_ref ? RC_CYC - 1 : ((rc_cnt > 0) ? rc_cnt - 1 : 0);
      n_ref  <= (dqm && act_ref && cmd == sdseq_pkg::CMD_REF) ? n_ref + 1 : n_ref;
      seen   <= seen || (cmd != sdseq_pkg::CMD_NOP);
      in_sr  <= (!cke && cmd == sdseq_pkg::CMD_REF) || (in_sr && !cke);
    end
  end

  // --------------------
  // properties
  // --------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  property p_mask_gate;
    dqm |-> cke && clk_run;
  endproperty
  property p_init_wait;
    cyc < INIT_CYC |-> cmd == sdseq_pkg::CMD_NOP;
  endproperty
  property p_pre_first;
    !seen && cmd != sdseq_pkg::CMD_NOP |-> cmd == sdseq_pkg::CMD_PRE
      && addr[`SDSEQ_ALL_BANKS_BIT];
  endproperty
  property p_pre_mrs;
    dqm && cmd == sdseq_pkg::CMD_PRE |=> (cmd == sdseq_pkg::CMD_NOP) [*2]
      ##1 cmd == sdseq_pkg::CMD_MRS;
  endproperty
  property p_mrs_gap;
    cmd == sdseq_pkg::CMD_MRS |=> cmd == sdseq_pkg::CMD_NOP ##1 cmd == sdseq_pkg::CMD_REF;
  endproperty
  property p_two_ref;
    $fell(dqm) |-> n_ref >= 2;
  endproperty
  property p_rc;
    rc_cnt != 0 |-> !act_ref;
  endproperty
  property p_sr_entry;
    $fell(cke) && !ras_n |-> !cs_n && !cas_n ##1 !clk_run && !cke;
  endproperty
  property p_sr_hold;
    !cke && $past(cke) && cmd == sdseq_pkg::CMD_REF |=> !cke [*6];
  endproperty
  property p_clk_first;
    $rose(cke) |-> clk_run && $past(clk_run, 4);
  endproperty
  property p_exit_desel;
    $rose(cke) && in_sr |-> (cs_n && cke) [*8] ##1 (cs_n && cke);
  endproperty

  a_mask_gate: assert property (p_mask_gate) else $error("gate low in init");
  a_init_wait: assert property (p_init_wait) else $error("early command");
  a_pre_first: assert property (p_pre_first) else $error("no precharge first");
  a_pre_mrs: assert property (p_pre_mrs) else $error("mode set timing");
  a_mrs_gap: assert property (p_mrs_gap) else $error("mode set gap");
  a_two_ref: assert property (p_two_ref) else $error("too few refreshes");
  a_rc: assert property (p_rc) else $error("row cycle too short");
  a_sr_entry: assert property (p_sr_entry) else $error("bad entry");
  a_sr_hold: assert property (p_sr_hold) else $error("hold too short");
  a_clk_first: assert property (p_clk_first) else $error("clock not settled");
  a_exit_desel: assert property (p_exit_desel) else $error("exit not deselected");

  c_init: cover property ($fell(dqm));
  c_sr: cover property ($rose(cke) && in_sr);
  c_susp: cover property ($fell(cke) && ras_n);
  c_act: cover property (act_ref && cmd == sdseq_pkg::CMD_ACT && ba != 2'h0);
endmodule

/* File: test/sdram_init_self_refresh_seq_tb.sv */
// self-checking bench: init, commands, suspension, self-refresh
`timescale 1ns/1ns
`include "sdseq_cfg.svh"

module sdram_init_self_refresh_seq_tb;
  // --------------------
  // set-up
  // --------------------
  // short init wait keeps the run brief; counts below follow from it
  localparam int INIT_CYC = 20;
  localparam int RC       = 9;
  logic                     clk, rst, burst_refresh, sr_req, suspend_req, cmd_valid;
  logic [`SDSEQ_ADDR_W-1:0] mode_word, cmd_addr, mode_reg;
  logic [`SDSEQ_BANK_W-1:0] cmd_bank;
  sdseq_pkg::sdseq_op_type  cmd_op;
  sdseq_pkg::sdseq_cmd_type cmd_code;
  logic                     cmd_ready, init_done, in_self_refresh;
  logic                     self_refresh, int_clk_en, burst_active, cmd_strobe;
  logic [3:0]               pins;
  int                       n_errors, compares, cyc, nref, n, t;

  sdseq_if i_sdseq_if ();
  assign pins = {i_sdseq_if.cs_n, i_sdseq_if.ras_n, i_sdseq_if.cas_n, i_sdseq_if.we_n};

  sdseq_ctrl #(.INIT_CYC(INIT_CYC), .BURST_REF(4)) i_sdseq_ctrl (
    .clk(clk), .rst(rst), .bus(i_sdseq_if.ctrl), .mode_word(mode_word),
    .burst_refresh(burst_refresh), .sr_req(sr_req), .suspend_req(suspend_req),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
    .cmd_ready(cmd_ready), .init_done(init_done), .in_self_refresh(in_self_refresh));
  sdseq_mem i_sdseq_mem (
    .clk(clk), .rst(rst), .bus(i_sdseq_if.mem), .self_refresh(self_refresh),
    .int_clk_en(int_clk_en), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .mode_reg(mode_reg),
    .burst_active(burst_active));
  sdseq_asserts #(.INIT_CYC(INIT_CYC), .RC_CYC(RC)) i_sdseq_asserts (
    .clk(clk), .rst(rst), .clk_run(i_sdseq_if.clk_run), .cke(i_sdseq_if.cke),
    .cs_n(i_sdseq_if.cs_n), .ras_n(i_sdseq_if.ras_n), .cas_n(i_sdseq_if.cas_n),
    .we_n(i_sdseq_if.we_n), .dqm(i_sdseq_if.dqm), .ba(i_sdseq_if.ba),
    .addr(i_sdseq_if.addr));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // entry refresh has the gate low and is left out of the count
  always @(posedge clk) if (i_sdseq_if.cke && pins == sdseq_pkg::CMD_REF) nref <= nref + 1;

  // --------------------
  // tasks
  // --------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask

  task automatic wait_cmd(output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (pins === sdseq_pkg::CMD_NOP && cnt < 100);
  endtask

  // request held until an edge samples ready high; pins show it after
  task automatic issue(input sdseq_pkg::sdseq_op_type op, input logic [11:0] a);
    int k;
    cmd_op = op;
    cmd_addr = a;
    cmd_bank = 2'h1;
    cmd_valid = 1'b1;
    #1;
    for (k = 0; k < 50 && cmd_ready !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  // --------------------
  // tests
  // --------------------
  initial begin
    rst = 1'b1;
    burst_refresh = 1'b0;
    sr_req = 1'b0;
    suspend_req = 1'b0;
    cmd_valid = 1'b0;
    mode_word = 12'h032;
    cmd_op = sdseq_pkg::OP_ACT;
    cmd_bank = 2'h0;
    cmd_addr = 12'h000;
    repeat (6) @(negedge clk);
    chk(i_sdseq_if.cke, 1);
    chk(i_sdseq_if.dqm, 1);
    chk(pins, sdseq_pkg::CMD_NOP);
    rst = 1'b0;
    wait_cmd(n);
    chk(n, INIT_CYC + 1);
    chk(pins, sdseq_pkg::CMD_PRE);
    chk(i_sdseq_if.addr[`SDSEQ_ALL_BANKS_BIT], 1);
    wait_cmd(n);
    chk(n, 3);
    chk(pins, sdseq_pkg::CMD_MRS);
    wait_cmd(n);
    chk(n, 2);
    chk(pins, sdseq_pkg::CMD_REF);
    wait_cmd(n);
    chk(n, RC);
    chk(pins, sdseq_pkg::CMD_REF);
    chk(mode_reg, mode_word);
    chk(i_sdseq_if.dqm, 1);
    chk(cmd_ready, 0);
    for (n = 0; n < 50 && init_done !== 1'b1; n++) @(negedge clk);
    chk(init_done, 1);
    chk(i_sdseq_if.dqm, 0);
    issue(sdseq_pkg::OP_ACT, 12'h123);
    chk(pins, sdseq_pkg::CMD_ACT);
    chk(i_sdseq_if.ba, 1);
    t = cyc;
    // an edge between two requests keeps cmd_valid from toggling in one step
    @(negedge clk);
    issue(sdseq_pkg::OP_REF, 12'h000);
    chk(cyc - t, RC);
    // the memory end registers what it samples, so it lags the pins by a cycle
    @(negedge clk);
    chk(cmd_code, sdseq_pkg::CMD_REF);
    chk(cmd_strobe, 1);
    issue(sdseq_pkg::OP_RD, 12'h040);
    @(negedge clk);
    chk(cmd_code, sdseq_pkg::CMD_RD);
    suspend_req = 1'b1;
    // state register first, then the pin register
    repeat (2) @(negedge clk);
    chk(i_sdseq_if.cke, 0);
    chk(int_clk_en, 1);
    @(negedge clk);
    chk(int_clk_en, 0);
    chk(cmd_ready, 0);
    repeat (6) @(negedge clk);
    chk(burst_active, 1);
    suspend_req = 1'b0;
    @(negedge clk);
    chk(int_clk_en, 0);
    repeat (2) @(negedge clk);
    chk(int_clk_en, 1);
    chk(burst_active, 1);
    @(negedge clk);
    chk(burst_active, 0);
    sr_req = 1'b1;
    for (n = 0; n < 50 && in_self_refresh !== 1'b1; n++) @(negedge clk);
    chk(in_self_refresh, 1);
    chk(self_refresh, 1);
    chk(cmd_strobe, 0);
    chk(cmd_ready, 0);
    chk(i_sdseq_if.cke, 0);
    sr_req = 1'b0;
    for (n = 0; n < 50 && i_sdseq_if.clk_run !== 1'b1; n++) @(negedge clk);
    chk(self_refresh, 1);
    for (n = 0; n < 50 && i_sdseq_if.cke !== 1'b1; n++) @(negedge clk);
    chk(n, 4);
    for (n = 0; n < 50 && pins === sdseq_pkg::CMD_DESEL; n++) @(negedge clk);
    chk(n, RC);
    chk(self_refresh, 0);
    chk(in_self_refresh, 0);
    burst_refresh = 1'b1;
    t = nref;
    sr_req = 1'b1;
    for (n = 0; n < 200 && in_self_refresh !== 1'b1; n++) @(negedge clk);
    chk(nref - t, 4);
    sr_req = 1'b0;
    for (n = 0; n < 300 && cmd_ready !== 1'b1; n++) @(negedge clk);
    chk(nref - t, 8);
    burst_refresh = 1'b0;
    issue(sdseq_pkg::OP_WR, 12'h010);
    @(negedge clk);
    chk(cmd_code, sdseq_pkg::CMD_WR);
    chk(burst_active, 1);
    issue(sdseq_pkg::OP_PRE, 12'h400);
    @(negedge clk);
    chk(cmd_code, sdseq_pkg::CMD_PRE);
    wrap_up();
  end
endmodule
